// >>> swdr_pkg.sv
package swdr_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 4000;
  // shortest toggle pulse that must be seen, in ns
  localparam int unsigned MIN_PULSE_NS = 150;
  localparam int unsigned MIN_PULSE_CYC = (MIN_PULSE_NS * 1000) / CLK_PERIOD_PS;
  // default periods in cycles; each system sets its own at the top
  localparam int unsigned RESET_TIMEOUT_CYC = 4096;
  localparam int unsigned WDOG_TIMEOUT_CYC = 65536;
  localparam int unsigned CNT_W = 32;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic RST_OUT_N_INIT = 1'b0;
  localparam logic RST_OUT_INIT = 1'b1;

  typedef enum logic [1:0] {
    SWDR_ST_HOLD,
    SWDR_ST_TIMEOUT,
    SWDR_ST_RUN
  } swdr_state_t;

endpackage

// >>> swdr_edge.sv
`timescale 1ns/1ps

// edge detector on the toggle input; every cycle-sampled level change counts, except while sys_rst is high
module swdr_edge (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic level_in,
  output logic edge_p
);

  logic last_q;

  // ------------------------------------------------------------------
  // previous level
  // ------------------------------------------------------------------
  // a 150 ns pulse spans many 4 ns cycles, so both its edges are caught
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      last_q <= level_in; // track the pin so no false edge follows release
    end else begin
      last_q <= level_in;
    end
  end

  assign edge_p = (level_in != last_q) && !sys_rst;

endmodule

// >>> swdr_top.sv
`timescale 1ns/1ps

// Operation
// - reset_out_n is low while the supply is low, manual_reset_n is low, or the watchdog expired.
// - once all causes clear, reset stays asserted for the full reset timeout, then releases.
// - reset_out is the high-true copy with the same causes and the same timeout.
// - a low manual_reset_n holds reset, and the timeout runs after it returns high.
// - watchdog_toggle_in held at one level beyond the watchdog timeout forces a reset.
// - the watchdog count clears during reset, while manual_reset_n is low, and on any toggle edge.
// - the watchdog does not count while reset is asserted and restarts from zero after release.
// - a toggle pulse as short as 150 ns is recognised as an edge.
module swdr_top #(
  parameter int unsigned RESET_TIMEOUT_CYC = swdr_pkg::RESET_TIMEOUT_CYC,
  parameter int unsigned WDOG_TIMEOUT_CYC = swdr_pkg::WDOG_TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic supply_low,
  input wire logic manual_reset_n,
  input wire logic watchdog_toggle_in,
  output logic reset_out_n,
  output logic reset_out
);

  // last count of each period; both periods must be at least one cycle
  localparam int unsigned CW = swdr_pkg::CNT_W;
  localparam logic [CW-1:0] RST_LAST = CW'(RESET_TIMEOUT_CYC - 1);
  localparam logic [CW-1:0] WDG_LAST = CW'(WDOG_TIMEOUT_CYC - 1);

  // ------------------------------------------------------------------
  // reset decode
  // ------------------------------------------------------------------
  // one decode feeds both pins, so the two polarities cannot drift apart
  function automatic logic hold_reset(input logic any_cause,
    input swdr_pkg::swdr_state_t st,
    input logic [swdr_pkg::CNT_W-1:0] cnt);
    return any_cause || st == swdr_pkg::SWDR_ST_HOLD
      || (st == swdr_pkg::SWDR_ST_TIMEOUT && cnt != RST_LAST);
  endfunction

  swdr_pkg::swdr_state_t state_q;
  logic [swdr_pkg::CNT_W-1:0] rst_cnt_q;
  logic [swdr_pkg::CNT_W-1:0] wdg_cnt_q;
  logic wdg_expire;
  logic cause;
  logic toggle_edge;
  logic asserted;
  logic [swdr_pkg::CNT_W-1:0] quiet_q;

  // ------------------------------------------------------------------
  // toggle edge
  // ------------------------------------------------------------------
  swdr_edge u_edge (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .level_in(watchdog_toggle_in),
    .edge_p(toggle_edge)
  );

  // ------------------------------------------------------------------
  // causes
  // ------------------------------------------------------------------
  // expiry is a one-cycle cause; a kick landing on the last count wins
  // so a cpu that kicks right at the limit is never reset
  assign wdg_expire = (state_q == swdr_pkg::SWDR_ST_RUN) && (wdg_cnt_q == WDG_LAST) && !toggle_edge;
  assign cause = supply_low || !manual_reset_n || wdg_expire;
  assign asserted = (state_q != swdr_pkg::SWDR_ST_RUN);

  // ------------------------------------------------------------------
  // reset sequencer
  // ------------------------------------------------------------------
  // hold while any cause stands, then time out; a new cause restarts
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= swdr_pkg::SWDR_ST_HOLD;
    end else begin
      case (state_q)
        swdr_pkg::SWDR_ST_HOLD: begin
          if (!supply_low && manual_reset_n) begin
            state_q <= swdr_pkg::SWDR_ST_TIMEOUT;
          end
        end
        swdr_pkg::SWDR_ST_TIMEOUT: begin
          if (supply_low || !manual_reset_n) begin
            state_q <= swdr_pkg::SWDR_ST_HOLD;
          end else if (rst_cnt_q == RST_LAST) begin
            state_q <= swdr_pkg::SWDR_ST_RUN;
          end
        end
        default: begin
          if (supply_low || !manual_reset_n) begin
            state_q <= swdr_pkg::SWDR_ST_HOLD;
          end else if (wdg_expire) begin
            state_q <= swdr_pkg::SWDR_ST_TIMEOUT;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // reset timeout counter
  // ------------------------------------------------------------------
  // clears to zero after the last count so it never wraps past the period
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rst_cnt_q <= '0;
    end else if (state_q == swdr_pkg::SWDR_ST_TIMEOUT && !supply_low && manual_reset_n
                 && rst_cnt_q != RST_LAST) begin
      rst_cnt_q <= rst_cnt_q + 1'b1;
    end else begin
      rst_cnt_q <= '0;
    end
  end

  // ------------------------------------------------------------------
  // watchdog counter
  // ------------------------------------------------------------------
  // frozen at zero through reset, so a fresh full period follows release;
  // the period after a release edge is as long as the one after a kick edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wdg_cnt_q <= '0;
    end else if (asserted || !manual_reset_n || toggle_edge || wdg_expire) begin
      wdg_cnt_q <= '0;
    end else begin
      wdg_cnt_q <= wdg_cnt_q + 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // registered so both polarities change on the same edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reset_out_n <= swdr_pkg::RST_OUT_N_INIT;
      reset_out <= swdr_pkg::RST_OUT_INIT;
    end else begin
      reset_out_n <= !hold_reset(cause, state_q, rst_cnt_q);
      reset_out <= hold_reset(cause, state_q, rst_cnt_q);
    end
  end

  // ------------------------------------------------------------------
  // quiet span, checking aid
  // ------------------------------------------------------------------
  // cycles since the last cause, kept apart from the sequencer so the
  // minimum reset length is judged against an independent count
  always_ff @(posedge mclk) begin
    if (sys_rst || cause) begin
      quiet_q <= '0;
    end else if (quiet_q != '1) begin
      quiet_q <= quiet_q + 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // checks: causes
  // ------------------------------------------------------------------
  // every cause shows on the pins one edge after it is sampled
  chk_supply_asserts: assert property (@(posedge mclk) disable iff (sys_rst)
    supply_low |=> !reset_out_n)
    else $error("supply low did not assert reset");
  chk_manual_holds: assert property (@(posedge mclk) disable iff (sys_rst)
    !manual_reset_n |=> reset_out)
    else $error("manual reset not held");
  chk_manual_restart: assert property (@(posedge mclk) disable iff (sys_rst)
    !manual_reset_n |=> state_q == swdr_pkg::SWDR_ST_HOLD && rst_cnt_q == '0)
    else $error("manual reset did not restart the timeout");
  chk_polarity_pair: assert property (@(posedge mclk) disable iff (sys_rst)
    reset_out == !reset_out_n)
    else $error("outputs disagree");

  // ------------------------------------------------------------------
  // checks: timeout
  // ------------------------------------------------------------------
  // release only after a full period free of any cause
  chk_timeout_held: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(manual_reset_n) && !supply_low |=> reset_out [*2])
    else $error("release too early");
  chk_release_run: assert property (@(posedge mclk) disable iff (sys_rst)
    state_q == swdr_pkg::SWDR_ST_TIMEOUT && rst_cnt_q == RST_LAST && !supply_low && manual_reset_n
      |=> state_q == swdr_pkg::SWDR_ST_RUN && reset_out_n)
    else $error("no release at the end of the timeout");
  chk_full_timeout: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(reset_out_n) |-> quiet_q >= RESET_TIMEOUT_CYC)
    else $error("release before a full timeout");
  chk_count_bound: assert property (@(posedge mclk) disable iff (sys_rst)
    rst_cnt_q <= RST_LAST)
    else $error("reset counter overran");

  // ------------------------------------------------------------------
  // checks: watchdog
  // ------------------------------------------------------------------
  // counting, clearing and expiry of the kick timer
  chk_wdog_frozen: assert property (@(posedge mclk) disable iff (sys_rst)
    asserted |=> wdg_cnt_q == '0)
    else $error("watchdog counted in reset");
  chk_wdog_counts: assert property (@(posedge mclk) disable iff (sys_rst)
    state_q == swdr_pkg::SWDR_ST_RUN && manual_reset_n && !toggle_edge && !wdg_expire
      |=> wdg_cnt_q == $past(wdg_cnt_q) + 1'b1)
    else $error("watchdog did not count while running");
  chk_edge_clears: assert property (@(posedge mclk) disable iff (sys_rst)
    toggle_edge |=> wdg_cnt_q == '0)
    else $error("edge did not clear watchdog");
  chk_expire_resets: assert property (@(posedge mclk) disable iff (sys_rst)
    wdg_expire && !supply_low && manual_reset_n |=> state_q == swdr_pkg::SWDR_ST_TIMEOUT ##1 reset_out)
    else $error("expiry without reset");
  chk_expiry_output: assert property (@(posedge mclk) disable iff (sys_rst)
    wdg_expire |=> !reset_out_n)
    else $error("expiry did not reach the pin");
  chk_pulse_seen: assert property (@(posedge mclk) disable iff (sys_rst)
    $changed(watchdog_toggle_in) |-> toggle_edge)
    else $error("toggle missed");

  // ------------------------------------------------------------------
  // covers
  // ------------------------------------------------------------------
  // the main scenarios a run should reach
  cov_release: cover property (@(posedge mclk) disable iff (sys_rst) $rose(reset_out_n));
  cov_wdog_expire: cover property (@(posedge mclk) disable iff (sys_rst) wdg_expire);
  cov_manual: cover property (@(posedge mclk) disable iff (sys_rst) $fell(manual_reset_n));
  cov_supply: cover property (@(posedge mclk) disable iff (sys_rst) $rose(supply_low));
  cov_kick: cover property (@(posedge mclk) disable iff (sys_rst) toggle_edge && state_q == swdr_pkg::SWDR_ST_RUN);

endmodule

// >>> swdr_cpu_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// far side: cpu firmware kicking the watchdog
// ------------------------------------------------------------
module swdr_cpu_model #(
  parameter int KICK_CYC = 5
) (
  input wire logic mclk,
  input wire logic kick_en,
  input wire logic reset_out_n,
  output logic watchdog_toggle_in = 1'b0
);
  int cnt = 0;
  // a cpu held in reset runs no code, so it stops kicking
  always @(negedge mclk) begin
    if (kick_en && reset_out_n === 1'b1) begin
      cnt <= (cnt == KICK_CYC - 1) ? 0 : cnt + 1;
      if (cnt == KICK_CYC - 1) watchdog_toggle_in <= ~watchdog_toggle_in;
    end
  end
endmodule

// >>> swdr_top_bench.sv
`timescale 1ns/1ps

module swdr_top_bench;
  localparam int RT = 8;
  localparam int WT = 20;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic supply_low = 1'b0;
  logic manual_reset_n = 1'b1;
  logic kick_en = 1'b1;
  logic watchdog_toggle_in;
  logic reset_out_n;
  logic reset_out;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;

  swdr_top #(.RESET_TIMEOUT_CYC(RT), .WDOG_TIMEOUT_CYC(WT)) dut (.mclk(mclk), .sys_rst(sys_rst),
    .supply_low(supply_low), .manual_reset_n(manual_reset_n), .watchdog_toggle_in(watchdog_toggle_in),
    .reset_out_n(reset_out_n), .reset_out(reset_out));
  swdr_cpu_model cpu (.mclk(mclk), .kick_en(kick_en), .reset_out_n(reset_out_n),
    .watchdog_toggle_in(watchdog_toggle_in));

  initial begin
    forever #2 mclk = ~mclk;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    if (errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // counts cycles until reset_out_n reaches lvl; the bound cuts a hang
  task automatic wait_lvl(input logic lvl, input int lo, input int hi);
    int k;
    k = 0;
    while (reset_out_n !== lvl && k < hi) begin
      @(negedge mclk);
      k++;
    end
    chk({k >= lo, reset_out_n}, {1'b1, lvl});
    chk({reset_out_n, reset_out}, {lvl, ~lvl});
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_supply();
    @(negedge mclk) supply_low = 1'b1;
    repeat (2) @(negedge mclk);
    chk({reset_out_n, reset_out}, 2'b01);
    supply_low = 1'b0;
    wait_lvl(1'b1, RT + 1, RT + 1);
  endtask

  task automatic t_manual();
    @(negedge mclk) manual_reset_n = 1'b0;
    repeat (RT + 6) @(negedge mclk);
    chk({reset_out_n, reset_out}, 2'b01);
    manual_reset_n = 1'b1;
    wait_lvl(1'b1, RT + 1, RT + 1);
  endtask

  task automatic t_watchdog();
    repeat (3 * WT) @(negedge mclk);
    chk({reset_out_n, reset_out}, 2'b10);
    // stop just after a kick so the silent span starts at a known edge
    @(watchdog_toggle_in);
    @(negedge mclk) kick_en = 1'b0;
    wait_lvl(1'b0, WT, WT);
    wait_lvl(1'b1, RT, RT);
    wait_lvl(1'b0, WT, WT);
    kick_en = 1'b1;
    wait_lvl(1'b1, RT, RT);
  endtask

  // mid-run reset: outputs assert and a full timeout follows release
  task automatic t_sysrst();
    @(negedge mclk) sys_rst = 1'b1;
    repeat (2) @(negedge mclk);
    chk({reset_out_n, reset_out}, 2'b01);
    sys_rst = 1'b0;
    wait_lvl(1'b1, RT + 1, RT + 1);
  endtask

  // ------------------------------------------------------------
  // main sequence and hang limit
  // ------------------------------------------------------------
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      stop_test();
    end
  end

  initial begin
    repeat (2) @(negedge mclk);
    chk({reset_out_n, reset_out}, 2'b01);
    sys_rst = 1'b0;
    wait_lvl(1'b1, RT + 1, RT + 1);
    t_supply();
    t_manual();
    t_watchdog();
    t_sysrst();
    stop_test();
  end
endmodule
